// ---- core/keypad_monitor_command_interp.sv ----
// Keypad monitor: command interpreter for read, modify, run and abort
// Summary of operation
// - Any key press while idle raises the service request and starts the monitor.
// - On entry the display shows the pattern 00d000.
// - First key must be read, modify or run; anything else exits like abort.
// - An illegal key after a valid command exits back to the program.
// - Read: four hex keys form an address; show address and its byte.
// - Further read presses increment the address and refresh the display.
// - Modify in read mode plus two hex keys writes the shown address.
// - Modify: four address keys, two data keys; repeats increment the address.
// - Missing two hex data keys after modify ends the service.
// - Read after a completed modify switches to read mode.
// - Run: four hex keys give a start address; fourth key starts it.
// - Abort before the fourth run key cancels; afterwards nothing cancels.
// - Abort ends the service and returns to the interrupted program.
// - Hex keys go to a six-entry table, packed into address and data.
// - Address entry takes four hex keys, data entry two, via key acceptance.
// - The display keeps refreshing while a key is awaited.
// - Six seven-segment digits are time-multiplexed one at a time.
// - Sixteen hex keys plus read, modify, run and abort keys.
// - The code of the last accepted key is presented to the caller.
// - The display refresh keeps the caller's pointer unchanged.
`timescale 1ns/1ps
`default_nettype none
module keypad_monitor_command_interp
   import kpmon_pkg::*;
#(
   parameter int DWELL_CYCLES = DIGIT_CYCLES
)
(
   input wire logic clk,
   input wire logic srst,
   input wire key_s keyIn,
   input wire logic memAck,
   input wire logic [7:0] memRdata,
   output mem_req_s memReq,
   output logic monitorActive,
   output logic resumePulse,
   output logic runStart,
   output logic [15:0] runAddr,
   output logic [4:0] extKey,
   output logic [6:0] segments,
   output logic [5:0] digitEnable
);
   typedef enum {S_IDLE, S_CMD, S_ADDR, S_DATA, S_SHOW, S_FETCH, S_WRITE} state_e;

   state_e state_reg;
   state_e ret_reg;
   mode_e mode_reg;
   logic [2:0] cnt_reg;
   logic [3:0] hexTable_reg [TABLE_DEPTH];
   logic [15:0] addr_reg;
   logic [7:0] data_reg;
   logic [23:0] digits_reg;
   logic keyStrobe;
   logic [4:0] keyCode;
   logic isHex;
   logic [15:0] packedAddr;
   logic [7:0] packedData;

   // ****************************************
   // Key acceptance and display
   // ****************************************
   key_accept u_key
   (
      .clk(clk),
      .srst(srst),
      .keyIn(keyIn),
      .keyStrobe(keyStrobe),
      .keyCode(keyCode)
   );

   display_scanner #(.DWELL_CYCLES(DWELL_CYCLES)) u_disp
   (
      .clk(clk),
      .srst(srst),
      .digitsIn(digits_reg),
      .segments(segments),
      .digitEnable(digitEnable)
   );

   assign isHex = (keyCode < 5'(HEX_KEYS));
   assign packedAddr = {hexTable_reg[0], hexTable_reg[1], hexTable_reg[2], keyCode[3:0]};
   assign packedData = {hexTable_reg[4], keyCode[3:0]};

   // ****************************************
   // Entry table
   // ****************************************
   // six-entry table
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < TABLE_DEPTH; i++)
            hexTable_reg[i] <= 4'h0;
      end
      else if (keyStrobe && isHex && (state_reg == S_ADDR || state_reg == S_DATA))
         hexTable_reg[cnt_reg] <= keyCode[3:0];
   end

   // ****************************************
   // Extension register
   // ****************************************
   // key code out
   always_ff @(posedge clk)
   begin
      if (srst)
         extKey <= KEY_RESET;
      else if (keyStrobe)
         extKey <= keyCode;
   end

   // ****************************************
   // Display contents
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
         digits_reg <= DIGITS_RESET;
      else if (state_reg == S_IDLE && keyStrobe)
         digits_reg <= RECOG_PATTERN;
      else if (state_reg == S_FETCH && memAck)
         digits_reg <= {addr_reg, memRdata};
      else if (state_reg == S_WRITE && memAck)
         digits_reg <= {addr_reg, data_reg};
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= S_IDLE;
         ret_reg <= S_SHOW;
         mode_reg <= MODE_READ;
         cnt_reg <= CNT_FIRST;
         addr_reg <= ADDR_RESET;
         data_reg <= DATA_RESET;
         memReq <= MEM_IDLE;
         monitorActive <= 1'b0;
         resumePulse <= 1'b0;
         runStart <= 1'b0;
         runAddr <= ADDR_RESET;
      end
      else
      begin
         resumePulse <= 1'b0;
         runStart <= 1'b0;
         case (state_reg)
            S_IDLE:
               if (keyStrobe)
               begin
                  monitorActive <= 1'b1;
                  state_reg <= S_CMD;
               end
            S_CMD:
            begin
               cnt_reg <= CNT_FIRST;
               // Address entry by default; a non-command key overrides it below
               state_reg <= S_ADDR;
               case (keyCode)
                  KEY_READ: mode_reg <= MODE_READ;
                  KEY_MODIFY: mode_reg <= MODE_MODIFY;
                  KEY_RUN: mode_reg <= MODE_RUN;
                  default:
                  begin
                     monitorActive <= 1'b0;
                     resumePulse <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               endcase
            end
            S_ADDR:
               if (keyStrobe)
               begin
                  if (isHex && cnt_reg == CNT_ADDR_LAST)
                  begin
                     addr_reg <= packedAddr;
                     cnt_reg <= CNT_DATA_FIRST;
                     if (mode_reg == MODE_RUN)
                     begin
                        runStart <= 1'b1;
                        runAddr <= packedAddr;
                        monitorActive <= 1'b0;
                        state_reg <= S_IDLE;
                     end
                     else
                     begin
                        memReq <= '{req: 1'b1, write: 1'b0, addr: packedAddr, wdata: data_reg};
                        ret_reg <= (mode_reg == MODE_READ) ? S_SHOW : S_DATA;
                        state_reg <= S_FETCH;
                     end
                  end
                  else if (isHex)
                     cnt_reg <= cnt_reg + 3'h1;
                  else
                  begin
                     monitorActive <= 1'b0;
                     resumePulse <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end
            S_DATA:
               if (keyStrobe)
               begin
                  if (isHex && cnt_reg == CNT_DATA_LAST)
                  begin
                     data_reg <= packedData;
                     memReq <= '{req: 1'b1, write: 1'b1, addr: addr_reg, wdata: packedData};
                     state_reg <= S_WRITE;
                  end
                  else if (isHex)
                     cnt_reg <= cnt_reg + 3'h1;
                  else
                  begin
                     monitorActive <= 1'b0;
                     resumePulse <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end
            S_FETCH:
               if (memAck)
               begin
                  memReq <= MEM_IDLE;
                  data_reg <= memRdata;
                  state_reg <= ret_reg;
               end
            S_WRITE:
               if (memAck)
               begin
                  memReq <= MEM_IDLE;
                  state_reg <= S_SHOW;
               end
            S_SHOW:
               if (keyStrobe)
               begin
                  cnt_reg <= CNT_DATA_FIRST;
                  if (keyCode == KEY_MODIFY && mode_reg == MODE_READ)
                  begin
                     mode_reg <= MODE_MODIFY;
                     state_reg <= S_DATA;
                  end
                  else if (keyCode == KEY_READ || keyCode == KEY_MODIFY)
                  begin
                     mode_reg <= (keyCode == KEY_READ) ? MODE_READ : MODE_MODIFY;
                     addr_reg <= addr_reg + 16'h0001;
                     memReq <= '{req: 1'b1, write: 1'b0, addr: addr_reg + 16'h0001,
                                 wdata: data_reg};
                     ret_reg <= (keyCode == KEY_READ) ? S_SHOW : S_DATA;
                     state_reg <= S_FETCH;
                  end
                  else
                  begin
                     monitorActive <= 1'b0;
                     resumePulse <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   sequence runFourth;
      state_reg == S_ADDR && mode_reg == MODE_RUN && keyStrobe && isHex
         && cnt_reg == CNT_ADDR_LAST;
   endsequence
   sequence runPulseOnce;
      runStart && runAddr == $past(packedAddr) ##1 !runStart;
   endsequence

   service_start_a : assert property (state_reg == S_IDLE && keyStrobe |=> monitorActive)
      else $error("service not started by key");
   recog_shown_a : assert property (state_reg == S_IDLE && keyStrobe |=> digits_reg == RECOG_PATTERN)
      else $error("recognition pattern not shown");
   bad_first_a : assert property (state_reg == S_CMD && keyCode != KEY_READ && keyCode != KEY_MODIFY
         && keyCode != KEY_RUN |=> resumePulse && !monitorActive)
      else $error("bad first key did not exit");
   bad_sequence_a : assert property (state_reg == S_SHOW && keyStrobe && isHex |=> resumePulse)
      else $error("hex key in show did not exit");
   read_display_a : assert property (state_reg == S_FETCH && memAck
         |=> digits_reg == {$past(addr_reg), $past(memRdata)})
      else $error("display not address and data");
   read_step_a : assert property (state_reg == S_SHOW && keyStrobe && keyCode == KEY_READ
         |=> memReq.req && !memReq.write && addr_reg == $past(addr_reg) + 16'h0001)
      else $error("read key did not advance address");
   modify_write_a : assert property (state_reg == S_DATA && keyStrobe && isHex
         && cnt_reg == CNT_DATA_LAST |=> memReq.req && memReq.write
         && memReq.wdata == $past(packedData))
      else $error("data keys did not write");
   data_missing_a : assert property (state_reg == S_DATA && keyStrobe && !isHex
         |=> resumePulse ##1 !monitorActive)
      else $error("missing data did not end service");
   run_start_a : assert property (runFourth |=> runPulseOnce)
      else $error("run not started on fourth key");
   abort_exit_a : assert property (state_reg == S_ADDR && keyStrobe && keyCode == KEY_ABORT
         |=> !runStart && resumePulse && state_reg == S_IDLE)
      else $error("abort during entry not cancelled");
   ext_key_a : assert property (keyStrobe |=> extKey == $past(keyCode))
      else $error("key code not presented");
endmodule // keypad_monitor_command_interp
`default_nettype wire

// ---- include/kpmon_pkg.sv ----
// Shared constants and types for the keypad monitor
`default_nettype none
package kpmon_pkg;
   // ****************************************
   // Keypad codes
   // ****************************************
   localparam int HEX_KEYS = 16;
   localparam int CMD_KEYS = 4;
   localparam int KEY_W = 5;
   localparam logic [4:0] KEY_MODIFY = 5'h10;
   localparam logic [4:0] KEY_RUN = 5'h11;
   localparam logic [4:0] KEY_READ = 5'h12;
   localparam logic [4:0] KEY_ABORT = 5'h13;
   localparam logic [4:0] KEY_RESET = 5'h00;

   // ****************************************
   // Display
   // ****************************************
   localparam int DIGITS = 6;
   localparam logic [23:0] RECOG_PATTERN = 24'h00d000;
   localparam logic [23:0] DIGITS_RESET = 24'h000000;
   localparam logic [5:0] DIGIT_SEL_FIRST = 6'h20;
   localparam logic [6:0] SEG_RESET = 7'h00;
   localparam int CLK_MHZ = 200;
   localparam int DIGIT_DWELL_US = 1000;
   localparam int DIGIT_CYCLES = DIGIT_DWELL_US * CLK_MHZ;

   // ****************************************
   // Entry table and memory
   // ****************************************
   localparam int TABLE_DEPTH = 6;
   localparam logic [2:0] CNT_FIRST = 3'h0;
   localparam logic [2:0] CNT_ADDR_LAST = 3'h3;
   localparam logic [2:0] CNT_DATA_FIRST = 3'h4;
   localparam logic [2:0] CNT_DATA_LAST = 3'h5;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef enum {MODE_READ, MODE_MODIFY, MODE_RUN} mode_e;

   typedef struct packed {
      logic valid;
      logic [4:0] code;
   } key_s;

   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mem_req_s;

   localparam mem_req_s MEM_IDLE = '{req: 1'b0, write: 1'b0, addr: 16'h0000, wdata: 8'h00};
endpackage
`default_nettype wire

// ---- core/key_accept.sv ----
// Key press acceptor: one strobe per press, re-armed only by release
`timescale 1ns/1ps
`default_nettype none
module key_accept
   import kpmon_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire key_s keyIn,
   output logic keyStrobe,
   output logic [4:0] keyCode
);
   logic armed_reg;

   // ****************************************
   // Press detection
   // ****************************************
   // once per press
   // A key held through reset stays ignored until it is let go
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         armed_reg <= 1'b0;
         keyStrobe <= 1'b0;
         keyCode <= KEY_RESET;
      end
      else
      begin
         keyStrobe <= 1'b0;
         if (!keyIn.valid)
            armed_reg <= 1'b1;
         else if (armed_reg)
         begin
            armed_reg <= 1'b0;
            keyStrobe <= 1'b1;
            keyCode <= keyIn.code;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   single_press_a : assert property (keyStrobe |=> !keyStrobe)
      else $error("two strobes for one press");
   held_key_a : assert property (keyIn.valid && !armed_reg |=> !keyStrobe)
      else $error("strobe while key still held");
endmodule // key_accept
`default_nettype wire

// ---- core/display_scanner.sv ----
// Six-digit seven-segment scanner, one digit lit at a time
`timescale 1ns/1ps
`default_nettype none
module display_scanner
   import kpmon_pkg::*;
#(
   parameter int DWELL_CYCLES = DIGIT_CYCLES
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [23:0] digitsIn,
   output logic [6:0] segments,
   output logic [5:0] digitEnable
);
   localparam int CW = $clog2(DWELL_CYCLES + 1);
   localparam logic [CW-1:0] DWELL_LAST = CW'(DWELL_CYCLES - 1);

   logic [CW-1:0] dwell_reg;
   logic [2:0] scanIdx_reg;
   logic stepEn;

   function automatic logic [6:0] seg7(input logic [3:0] n);
      case (n)
         4'h0: seg7 = 7'h3f;
         4'h1: seg7 = 7'h06;
         4'h2: seg7 = 7'h5b;
         4'h3: seg7 = 7'h4f;
         4'h4: seg7 = 7'h66;
         4'h5: seg7 = 7'h6d;
         4'h6: seg7 = 7'h7d;
         4'h7: seg7 = 7'h07;
         4'h8: seg7 = 7'h7f;
         4'h9: seg7 = 7'h6f;
         4'ha: seg7 = 7'h77;
         4'hb: seg7 = 7'h7c;
         4'hc: seg7 = 7'h39;
         4'hd: seg7 = 7'h5e;
         4'he: seg7 = 7'h79;
         default: seg7 = 7'h71;
      endcase
   endfunction

   // ****************************************
   // Dwell divider
   // ****************************************
   // free-running refresh
   // Runs regardless of the interpreter so the display never freezes on a key wait
   always_ff @(posedge clk)
   begin
      if (srst || dwell_reg == DWELL_LAST)
         dwell_reg <= '0;
      else
         dwell_reg <= dwell_reg + 1'b1;
   end
   assign stepEn = (dwell_reg == DWELL_LAST);

   // ****************************************
   // Digit multiplexing
   // ****************************************
   // one digit lit
   // private digit pointer
   // Own scan index, so the caller's entry position is never disturbed
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         scanIdx_reg <= 3'h0;
         digitEnable <= DIGIT_SEL_FIRST;
         segments <= SEG_RESET;
      end
      else if (stepEn)
      begin
         scanIdx_reg <= (scanIdx_reg == 3'h5) ? 3'h0 : scanIdx_reg + 3'h1;
         digitEnable <= 6'h20 >> scanIdx_reg;
         segments <= seg7(digitsIn[23 - 4*scanIdx_reg -: 4]);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   one_digit_a : assert property ($onehot(digitEnable))
      else $error("not exactly one digit enabled");
endmodule // display_scanner
`default_nettype wire

// ---- testbench/host_mem_model.sv ----
// Host memory model answering the monitor's read and write requests
`timescale 1ns/1ps
`default_nettype none
module host_mem_model
   import kpmon_pkg::*;
(
   input wire logic clk,
   input wire mem_req_s memReq,
   output logic memAck,
   output logic [7:0] memRdata
);
   logic [7:0] store [logic [15:0]];
   int seed;
   int dly;

   // ****************************************
   // Request service
   // ****************************************
   // host acks after 0 to 3 cycles
   // The interrupted program is never busy, so a key press may enter the monitor at any time.
   initial
   begin
      seed = 32'hbbd6;
      memAck = 1'b0;
      memRdata = 8'h00;
      forever
      begin
         @(posedge clk);
         #1;
         // Data not qualified by an ack keeps moving, so a stale sample never matches
         memRdata = ~memRdata;
         if (memReq.req === 1'b1)
         begin
            dly = $unsigned($random(seed)) % 4;
            repeat (dly) @(posedge clk);
            #1;
            memAck = 1'b1;
            memRdata = store.exists(memReq.addr) ? store[memReq.addr] :
               (memReq.addr[7:0] ^ memReq.addr[15:8] ^ 8'ha5);
            if (memReq.write === 1'b1)
               store[memReq.addr] = memReq.wdata;
            @(posedge clk);
            #1;
            memAck = 1'b0;
            memRdata = ~memRdata;
         end
      end
   end
endmodule // host_mem_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the keypad monitor command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench
   import kpmon_pkg::*;
;
   // Short dwell keeps a full scan at 24 cycles
   localparam int DWELL = 4;
   logic clk, srst, memAck, monitorActive, resumePulse, runStart;
   key_s keyIn;
   logic [7:0] memRdata;
   mem_req_s memReq;
   logic [15:0] runAddr, lastAddr, a;
   logic [4:0] extKey;
   logic [6:0] segments;
   logic [5:0] digitEnable;
   logic [6:0] shown [0:5];
   logic [7:0] lastWdata, d;
   logic lastWrite;
   logic reqPrev = 1'b0;
   int reqs = 0, resumes = 0, runs = 0, cycles = 0;
   int miscompares = 0, checked = 0, nReq = 0, nRes = 0, seed;

   keypad_monitor_command_interp #(.DWELL_CYCLES(DWELL)) dut_u (.clk(clk), .srst(srst),
      .keyIn(keyIn), .memAck(memAck), .memRdata(memRdata), .memReq(memReq),
      .monitorActive(monitorActive), .resumePulse(resumePulse), .runStart(runStart),
      .runAddr(runAddr), .extKey(extKey), .segments(segments), .digitEnable(digitEnable));
   host_mem_model partner_u (.clk(clk), .memReq(memReq), .memAck(memAck),
      .memRdata(memRdata));

   // ****************************************
   // Helpers
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      reqPrev <= memReq.req;
      if (memReq.req === 1'b1 && reqPrev !== 1'b1)
      begin
         reqs <= reqs + 1;
         lastAddr <= memReq.addr;
         lastWrite <= memReq.write;
         lastWdata <= memReq.wdata;
      end
      // Pulses are counted per high cycle, so a stuck pulse shows as an extra count
      if (resumePulse === 1'b1) resumes <= resumes + 1;
      if (runStart === 1'b1) runs <= runs + 1;
      for (int i = 0; i < 6; i++)
         if (digitEnable[5 - i] === 1'b1) shown[i] <= segments;
   end

   always @(posedge clk)
      if (cycles == 60000)
      begin
         miscompares++;
         give_verdict();
      end

   function automatic logic [6:0] seg_of(input logic [3:0] n);
      logic [6:0] t [0:15];
      t = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
            7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
      return t[n];
   endfunction

   function automatic logic [7:0] byte_at(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'ha5;
   endfunction

   task automatic check_value(input logic [47:0] seen, input logic [47:0] want);
      checked++;
      if (seen !== want)
      begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict();
      if (miscompares == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Called at a falling edge; release shows an inverted code on the lines
   task automatic press(input logic [4:0] c, input int hold);
      keyIn = '{valid: 1'b1, code: c};
      repeat (hold) @(negedge clk);
      keyIn = '{valid: 1'b0, code: ~c};
      repeat (6) @(negedge clk);
   endtask

   task automatic enter(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
         press({1'b0, v[4 * i +: 4]}, 2);
   endtask

   task automatic mem_wait();
      nReq++;
      for (int i = 0; i < 200 && !(reqs == nReq && memReq.req === 1'b0); i++)
         @(negedge clk);
      check_value(48'(reqs), 48'(nReq));
   endtask

   task automatic show_check(input logic [23:0] v);
      logic [41:0] seen;
      logic [41:0] want;
      repeat (8 * DWELL) @(negedge clk);
      for (int i = 0; i < 6; i++)
      begin
         seen[41 - 7 * i -: 7] = shown[i];
         want[41 - 7 * i -: 7] = seg_of(v[23 - 4 * i -: 4]);
      end
      check_value(48'(seen), 48'(want));
      check_value(48'($onehot(digitEnable)), 48'h1);
   endtask

   task automatic exit_check();
      nRes++;
      check_value(48'(resumes), 48'(nRes));
      check_value(48'(monitorActive), 48'h0);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      seed = 32'hbbd6;
      keyIn = '{valid: 1'b0, code: 5'h00};
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      check_value(48'(digitEnable), 48'h20);
      // The acceptor arms only after an edge with no key held
      @(negedge clk);
      for (int k = 0; k < 4; k++)
      begin
         press(KEY_READ, 2);
         check_value(48'(monitorActive), 48'h1);
         check_value(48'(extKey), 48'(KEY_READ));
         show_check(RECOG_PATTERN);
         a = 16'($random(seed));
         enter(a, 4);
         mem_wait();
         check_value(48'({lastWrite, lastAddr}), 48'({1'b0, a}));
         show_check({a, byte_at(a)});
         press(KEY_READ, 20);
         mem_wait();
         check_value(48'(lastAddr), 48'(a + 16'h0001));
         show_check({a + 16'h0001, byte_at(a + 16'h0001)});
         d = 8'($random(seed));
         press(KEY_MODIFY, 2);
         enter(16'(d), 2);
         mem_wait();
         check_value(48'({lastWrite, lastAddr, lastWdata}), 48'({1'b1, a + 16'h0001, d}));
         show_check({a + 16'h0001, d});
         press({1'b0, d[3:0]}, 2);
         exit_check();
      end
      press(KEY_MODIFY, 2);
      a = 16'($random(seed));
      enter(a, 4);
      mem_wait();
      show_check({a, byte_at(a)});
      enter(16'(d), 2);
      mem_wait();
      check_value(48'({lastWrite, lastAddr, lastWdata}), 48'({1'b1, a, d}));
      show_check({a, d});
      press(KEY_MODIFY, 2);
      mem_wait();
      check_value(48'({lastWrite, lastAddr}), 48'({1'b0, a + 16'h0001}));
      enter(16'(~d), 2);
      mem_wait();
      check_value(48'({lastWrite, lastAddr, lastWdata}), 48'({1'b1, a + 16'h0001, ~d}));
      press(KEY_READ, 2);
      mem_wait();
      check_value(48'({lastWrite, lastAddr}), 48'({1'b0, a + 16'h0002}));
      press(KEY_ABORT, 2);
      exit_check();
      press(KEY_MODIFY, 2);
      enter(a, 4);
      mem_wait();
      press(KEY_RUN, 2);
      exit_check();
      for (int k = 0; k < HEX_KEYS; k++)
      begin
         press(5'(k), 2);
         exit_check();
      end
      // Reset in mid-service with a key held through it
      press(KEY_READ, 2);
      check_value(48'(monitorActive), 48'h1);
      keyIn = '{valid: 1'b1, code: KEY_READ};
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      check_value(48'(monitorActive), 48'h0);
      keyIn = '{valid: 1'b0, code: ~KEY_READ};
      @(negedge clk);
      press(KEY_RUN, 2);
      enter(a, 3);
      press(KEY_ABORT, 2);
      exit_check();
      check_value(48'(runs), 48'h0);
      a = 16'($random(seed));
      press(KEY_RUN, 2);
      enter(a, 4);
      check_value(48'(runs), 48'h1);
      check_value(48'(runAddr), 48'(a));
      check_value(48'(resumes), 48'(nRes));
      check_value(48'(reqs), 48'(nReq));
      check_value(48'(monitorActive), 48'h0);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
